/* File: hw/pdcrpb_pkg.sv */
//==========================================================
// Function
// - Leaving inrush for normal releases power good; pass switch on, no limiting.
// - Inrush time ms is capacitance uF times voltage V over 103.
// - Requested 4-6: open/open Class 3, open/low Class 4, msb low requested.
// - Requested 7-8: adds msb low lsb open Class 6, both low requested.
// - PSE type flag floats for Type 1/2, driven low for Type 3/4.
// - Autoclass select tied low disables; floating requests measurement from a Type 3/4 PSE.
// - During inrush power good output actively held low.
//==========================================================
package pdcrpb_pkg;
   localparam int          CLK_MHZ        = 125;
   localparam int          POWER_DELAY_MS = 80;
   localparam int          POWER_DELAY_CYC = POWER_DELAY_MS * CLK_MHZ * 1000;
   localparam int          INRUSH_DIVISOR = 103;
   localparam logic [3:0]  CLASS_RST      = 4'h0;
   localparam logic [3:0]  CLASS_3        = 4'h3;
   localparam logic [3:0]  CLASS_4        = 4'h4;
   localparam logic [3:0]  CLASS_6        = 4'h6;
   localparam logic [3:0]  CLASS_7        = 4'h7;
   typedef enum logic [2:0] {
      PDCRPB_IDLE   = 3'h0,
      PDCRPB_CLASS  = 3'h1,
      PDCRPB_INRUSH = 3'h2,
      PDCRPB_NORMAL = 3'h3
   } pdcrpb_state_t;
endpackage

/* File: hw/pdcrpb_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pdcrpb_sync
   import pdcrpb_pkg::*;
#(
   parameter int WIDTH = 1
)(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         dout <= '0;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            dout <= s3;
      end
   end
endmodule
`default_nettype wire

/* File: hw/pd_class_result_power_budget.sv */
`timescale 1ns/1ps
`default_nettype none
module pd_class_result_power_budget
   import pdcrpb_pkg::*;
#(
   parameter int POWER_DELAY = POWER_DELAY_CYC
)(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       portAboveUvlo,
   input  wire logic       inrushDone,
   input  wire logic       classDone,
   input  wire logic [3:0] requestedClass,
   input  wire logic [3:0] assignedClass,
   input  wire logic       pseType34,
   input  wire logic       autoclassSelectFloat,
   output logic            powerGoodOe,
   output logic            powerGoodOut,
   output logic            passSwitchFullOn,
   output logic            currentLimitOn,
   output logic            classMsbOe,
   output logic            classLsbOe,
   output logic            classMsbOut,
   output logic            classLsbOut,
   output logic            pseTypeFlagOe,
   output logic            pseTypeFlagOut,
   output logic            autoclassRequest,
   output logic            powerDelayDone
);
   // Elaboration check on the delay count
   if (POWER_DELAY < 1)
   begin : gBadDelay
      $error("POWER_DELAY must be at least one cycle");
   end

   //==========================================================
   // Input synchronisers
   //==========================================================
   logic [3:0] syncIn;
   logic [3:0] syncOut;
   logic       uvloS;
   logic       inrushDoneS;
   logic       classDoneS;
   logic       acsS;

   assign syncIn = {autoclassSelectFloat, classDone, inrushDone, portAboveUvlo};

   pdcrpb_sync #(.WIDTH(4)) uSync (
      .clk  (clk),
      .rst  (rst),
      .din  (syncIn),
      .dout (syncOut)
   );

   assign uvloS       = syncOut[0];
   assign inrushDoneS = syncOut[1];
   assign classDoneS  = syncOut[2];
   assign acsS        = syncOut[3];

   //==========================================================
   // Start-up sequence
   //==========================================================
   pdcrpb_state_t state;
   pdcrpb_state_t next_state;

   always_comb
   begin
      next_state = state;
      case (state)
         PDCRPB_IDLE:
            if (classDoneS)
               next_state = PDCRPB_CLASS;
         PDCRPB_CLASS:
            if (uvloS)
               next_state = PDCRPB_INRUSH;
         PDCRPB_INRUSH:
            if (!uvloS)
               next_state = PDCRPB_IDLE;
            else if (inrushDoneS)
               next_state = PDCRPB_NORMAL;
         PDCRPB_NORMAL:
            if (!uvloS)
               next_state = PDCRPB_IDLE;
         default:
            next_state = PDCRPB_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state <= PDCRPB_IDLE;
      else
         state <= next_state;
   end

   // Power good low in inrush, released in normal; switch fully on in normal
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         powerGoodOe      <= 1'b1;
         powerGoodOut     <= 1'b0;
         passSwitchFullOn <= 1'b0;
         currentLimitOn   <= 1'b0;
      end
      else
      begin
         powerGoodOut     <= 1'b0;
         powerGoodOe      <= (next_state != PDCRPB_NORMAL);
         passSwitchFullOn <= (next_state == PDCRPB_NORMAL);
         currentLimitOn   <= (next_state == PDCRPB_INRUSH);
      end
   end

   //==========================================================
   // Class result and PSE type indicators
   //==========================================================
   logic next_msbLow;
   logic next_lsbLow;

   always_comb
   begin
      next_msbLow = 1'b0;
      next_lsbLow = 1'b0;
      if (requestedClass >= CLASS_4)
      begin
         if (assignedClass == CLASS_4)
            next_lsbLow = 1'b1;
         else if (assignedClass == CLASS_6 && requestedClass >= CLASS_7)
            next_msbLow = 1'b1;
         else if (assignedClass > CLASS_3 && assignedClass == requestedClass)
         begin
            next_msbLow = 1'b1;
            next_lsbLow = (requestedClass >= CLASS_7);
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         classMsbOe     <= 1'b0;
         classLsbOe     <= 1'b0;
         pseTypeFlagOe  <= 1'b0;
         classMsbOut    <= 1'b0;
         classLsbOut    <= 1'b0;
         pseTypeFlagOut <= 1'b0;
      end
      else
      begin
         classMsbOut    <= 1'b0;
         classLsbOut    <= 1'b0;
         pseTypeFlagOut <= 1'b0;
         if (state == PDCRPB_IDLE && classDoneS)
         begin
            classMsbOe    <= next_msbLow;
            classLsbOe    <= next_lsbLow;
            pseTypeFlagOe <= pseType34;
         end
         else if (state != PDCRPB_IDLE && next_state == PDCRPB_IDLE)
         begin
            classMsbOe    <= 1'b0;
            classLsbOe    <= 1'b0;
            pseTypeFlagOe <= 1'b0;
         end
      end
   end

   // Autoclass request only when pin floats and PSE is Type 3/4
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         autoclassRequest <= 1'b0;
      else
         autoclassRequest <= acsS && pseType34 && (state == PDCRPB_IDLE);
   end

   //==========================================================
   // Delay from undervoltage release to increased power
   //==========================================================
   logic [31:0] delayCnt;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         delayCnt       <= '0;
         powerDelayDone <= 1'b0;
      end
      else if (!uvloS)
      begin
         delayCnt       <= '0;
         powerDelayDone <= 1'b0;
      end
      else if (delayCnt < 32'(POWER_DELAY))
         delayCnt <= delayCnt + 32'h1;
      else
         powerDelayDone <= 1'b1;
   end

   //==========================================================
   // Checks
   //==========================================================
   // Outputs follow next_state, so they match state in the same cycle
   a_pg_low_inrush: assert property (@(posedge clk) disable iff (rst)
      state == PDCRPB_INRUSH |-> powerGoodOe)
      else $error("power good not held low during inrush");
   a_pg_release: assert property (@(posedge clk) disable iff (rst)
      state == PDCRPB_NORMAL |-> !powerGoodOe && passSwitchFullOn && !currentLimitOn)
      else $error("power good not released in normal state");
   a_limit_inrush: assert property (@(posedge clk) disable iff (rst)
      currentLimitOn |-> state == PDCRPB_INRUSH)
      else $error("limiting outside inrush");
   a_class_lsb_four: assert property (@(posedge clk) disable iff (rst)
      state == PDCRPB_IDLE && classDoneS && requestedClass >= CLASS_4
      && assignedClass == CLASS_4 |=> classLsbOe && !classMsbOe)
      else $error("class 4 encoding wrong");
   a_class_three_open: assert property (@(posedge clk) disable iff (rst)
      state == PDCRPB_IDLE && classDoneS && assignedClass <= CLASS_3
      |=> !classLsbOe && !classMsbOe)
      else $error("class 3 encoding wrong");
   a_class_six_hi: assert property (@(posedge clk) disable iff (rst)
      state == PDCRPB_IDLE && classDoneS && requestedClass >= CLASS_7
      && assignedClass == CLASS_6 |=> classMsbOe && !classLsbOe)
      else $error("class 6 encoding wrong");
   a_pse_type: assert property (@(posedge clk) disable iff (rst)
      state == PDCRPB_IDLE && classDoneS |=> pseTypeFlagOe == $past(pseType34))
      else $error("pse type flag wrong");
   a_autoclass_off: assert property (@(posedge clk) disable iff (rst)
      !acsS |=> !autoclassRequest)
      else $error("autoclass requested while disabled");
   a_delay_early: assert property (@(posedge clk) disable iff (rst)
      $rose(uvloS) |-> !powerDelayDone [*8])
      else $error("power delay ended too early");
   a_open_drain: assert property (@(posedge clk) disable iff (rst)
      !powerGoodOut && !classMsbOut && !classLsbOut && !pseTypeFlagOut)
      else $error("open drain output driven high");

   c_normal: cover property (@(posedge clk) disable iff (rst)
      state == PDCRPB_INRUSH ##1 state == PDCRPB_NORMAL);
   c_class_req: cover property (@(posedge clk) disable iff (rst)
      classMsbOe && classLsbOe);
   c_delay: cover property (@(posedge clk) disable iff (rst) $rose(powerDelayDone));
   c_autoclass: cover property (@(posedge clk) disable iff (rst) autoclassRequest);
endmodule
`default_nettype wire

/* File: tb/pdcrpb_pse_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pdcrpb_pse_model
   import pdcrpb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       startClass,
   input  wire logic [3:0] grantClass,
   input  wire logic       grantType34,
   input  wire logic       powerOn,
   output logic            classDone,
   output logic [3:0]      assignedClass,
   output logic            pseType34,
   output logic            portAboveUvlo
);
   logic [3:0] holdCnt;
   //==========================================================
   // Class handshake, result released after hold
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         holdCnt       <= 4'h0;
         classDone     <= 1'b0;
         assignedClass <= 4'h0;
      end
      else if (startClass)
      begin
         holdCnt       <= 4'hc;
         classDone     <= 1'b1;
         assignedClass <= grantClass;
      end
      else if (holdCnt != 4'h0)
      begin
         holdCnt <= holdCnt - 4'h1;
         if (holdCnt == 4'h1)
         begin
            classDone     <= 1'b0;
            assignedClass <= ~assignedClass;
         end
      end
   end
   //==========================================================
   // Port voltage and PSE type
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         portAboveUvlo <= 1'b0;
         pseType34     <= 1'b0;
      end
      else
      begin
         portAboveUvlo <= powerOn;
         pseType34     <= grantType34;
      end
   end
endmodule
`default_nettype wire

/* File: tb/pd_class_result_power_budget_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pd_class_result_power_budget_tb_top;
   import pdcrpb_pkg::*;
   logic       clk, rst, inrushDone, autoclassSelectFloat, startClass, grantType34, powerOn;
   logic [3:0] requestedClass, grantClass, assignedClass;
   logic       portAboveUvlo, classDone, pseType34, powerGoodOe, powerGoodOut;
   logic       passSwitchFullOn, currentLimitOn, classMsbOe, classLsbOe, classMsbOut;
   logic       classLsbOut, pseTypeFlagOe, pseTypeFlagOut, autoclassRequest, powerDelayDone;
   int         mismatches = 0;
   int         checksDone = 0;
   int         cycles = 0;
   logic [3:0] reqTab [8] = '{4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h7, 4'h8};
   logic [3:0] asgTab [8] = '{4'h3, 4'h4, 4'h5, 4'h4, 4'h6, 4'h8, 4'h3, 4'h6};
   logic [7:0] typeTab = 8'h77;
   // Allowed load in tenths of a watt per case once the delay has passed
   logic [9:0] limTab [8] = '{10'h082, 10'h0ff, 10'h190, 10'h0ff,
                              10'h1fe, 10'h2c9, 10'h082, 10'h1fe};
   // Pull-up view of the open-drain pins
   wire logic  pgPin   = powerGoodOe ? powerGoodOut : 1'b1;
   wire logic  msbPin  = classMsbOe ? classMsbOut : 1'b1;
   wire logic  lsbPin  = classLsbOe ? classLsbOut : 1'b1;
   wire logic  flagPin = pseTypeFlagOe ? pseTypeFlagOut : 1'b1;

   pd_class_result_power_budget #(.POWER_DELAY(20)) uut (.clk(clk), .rst(rst),
      .portAboveUvlo(portAboveUvlo), .inrushDone(inrushDone), .classDone(classDone),
      .requestedClass(requestedClass), .assignedClass(assignedClass),
      .pseType34(pseType34), .autoclassSelectFloat(autoclassSelectFloat),
      .powerGoodOe(powerGoodOe), .powerGoodOut(powerGoodOut),
      .passSwitchFullOn(passSwitchFullOn), .currentLimitOn(currentLimitOn),
      .classMsbOe(classMsbOe), .classLsbOe(classLsbOe), .classMsbOut(classMsbOut),
      .classLsbOut(classLsbOut), .pseTypeFlagOe(pseTypeFlagOe),
      .pseTypeFlagOut(pseTypeFlagOut), .autoclassRequest(autoclassRequest),
      .powerDelayDone(powerDelayDone));
   pdcrpb_pse_model pse (.clk(clk), .rst(rst), .startClass(startClass),
      .grantClass(grantClass), .grantType34(grantType34), .powerOn(powerOn),
      .classDone(classDone), .assignedClass(assignedClass), .pseType34(pseType34),
      .portAboveUvlo(portAboveUvlo));

   //==========================================================
   // Helpers
   function automatic logic [1:0] expOe(input logic [3:0] req, input logic [3:0] asg);
      if (asg <= 4'h3)
         return 2'b00;
      if (asg == 4'h4)
         return 2'b01;
      if (asg == req)
         return {1'b1, req >= 4'h7};
      return 2'b10;
   endfunction

   // System view: assigned class decoded from the pins
   function automatic logic [3:0] sysClass(input logic [3:0] req, input logic msb,
                                           input logic lsb);
      if (msb)
         return lsb ? 4'h3 : 4'h4;
      if (req >= 4'h7 && lsb)
         return 4'h6;
      return req;
   endfunction

   // Maintain current threshold in mA
   function automatic logic [7:0] mpsMa(input logic [3:0] req, input logic msb);
      return (req >= 4'h5 && !msb) ? 8'h10 : 8'h0a;
   endfunction

   // Maintain on-time and dropout limit in ms
   function automatic logic [17:0] mpsTiming(input logic flag);
      return flag ? {9'h04b, 9'h0fa} : {9'h007, 9'h136};
   endfunction

   // Load the system allows itself, tenths of a watt; class 8 capped at 71.3 W
   function automatic logic [9:0] sysLimitDw(input logic [3:0] cls, input logic pg,
                                             input logic done);
      if (!pg)
         return 10'h000;
      if (!done || cls <= 4'h3)
         return 10'h082;
      case (cls)
         4'h4:    return 10'h0ff;
         4'h5:    return 10'h190;
         4'h6:    return 10'h1fe;
         4'h7:    return 10'h26c;
         default: return 10'h2c9;
      endcase
   endfunction

   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulseClass();
      @(posedge clk) startClass <= 1'b1;
      @(posedge clk) startClass <= 1'b0;
      waitc(16);
   endtask

   task automatic testDone();
      if (mismatches == 0 && checksDone > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   //==========================================================
   // One power-up sequence
   task automatic runCase(input int i);
      logic [1:0] oe;
      logic [3:0] sysCls;
      oe = expOe(reqTab[i], asgTab[i]);
      @(posedge clk);
      requestedClass       <= reqTab[i];
      grantClass           <= asgTab[i];
      grantType34          <= typeTab[i];
      autoclassSelectFloat <= i[0];
      waitc(8);
      `CHK(autoclassRequest, i[0] & typeTab[i])
      pulseClass();
      `CHK({msbPin, lsbPin}, ~oe)
      `CHK(flagPin, ~typeTab[i])
      @(posedge clk) powerOn <= 1'b1;
      waitc(8);
      `CHK({pgPin, currentLimitOn, passSwitchFullOn, powerDelayDone}, 4'h4)
      `CHK(portAboveUvlo & ~pgPin, 1'b1)
      @(posedge clk) inrushDone <= 1'b1;
      waitc(8);
      `CHK({pgPin, currentLimitOn, passSwitchFullOn}, 3'h5)
      sysCls = sysClass(reqTab[i], msbPin, lsbPin);
      `CHK(sysCls, asgTab[i])
      `CHK(sysLimitDw(sysCls, pgPin, powerDelayDone), 10'h082)
      `CHK(mpsMa(reqTab[i], msbPin), (reqTab[i] >= 4'h5 && asgTab[i] >= 4'h5) ? 8'h10 : 8'h0a)
      `CHK(mpsTiming(flagPin), typeTab[i] ? {9'h007, 9'h136} : {9'h04b, 9'h0fa})
      `CHK(autoclassSelectFloat & ~flagPin, i[0] & typeTab[i])
      grantClass <= 4'h3;
      pulseClass();
      `CHK({msbPin, lsbPin}, ~oe)
      `CHK(powerDelayDone, 1'b1)
      `CHK(sysLimitDw(sysCls, pgPin, powerDelayDone), limTab[i])
      @(posedge clk);
      powerOn    <= 1'b0;
      inrushDone <= 1'b0;
      waitc(8);
      `CHK({pgPin, msbPin, lsbPin, flagPin}, 4'h7)
   endtask

   //==========================================================
   // Clock, timeout and main sequence
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         testDone();
      end
   end

   initial
   begin
      rst                  = 1'b1;
      inrushDone           = 1'b0;
      autoclassSelectFloat = 1'b0;
      startClass           = 1'b0;
      grantType34          = 1'b0;
      powerOn              = 1'b0;
      requestedClass       = 4'h4;
      grantClass           = 4'h3;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      waitc(2);
      `CHK({pgPin, msbPin, lsbPin, flagPin, currentLimitOn, passSwitchFullOn}, 6'h1c)
      for (int i = 0; i < 8; i++)
         runCase(i);
      testDone();
   end
endmodule
`default_nettype wire
